// ==== design/rtc_pkg.sv ====
// Package for the reload timer pair control block: register map, fields,
// reset values, clock-source and mode encodings.
// Assumes a single 25 MHz core clock and an AHB-Lite register port.
package rtc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] mode_off = 8'h04;
    localparam logic [7:0] stat_off = 8'h08;
    localparam logic [7:0] mask_off = 8'h0c;
    localparam logic [7:0] src_off = 8'h10;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int ctl_clk_ext_bit = 0;
    localparam int ctl_irq1_en_bit = 1;
    localparam int ctl_external_irq_pin_two_en_bit = 2;
    localparam int ctl_exp_n_bit = 3;
    localparam logic [7:0] ctrl_reset = 8'h09;

    // ----------------------------------------------------------------
    // Mode register fields
    // ----------------------------------------------------------------
    localparam int mode_reload_bit = 0;
    localparam int mode_sel_lo_bit = 2;
    localparam int mode_sel_hi_bit = 3;
    localparam int mode_wide_bit = 4;
    localparam logic [7:0] mode_reset = 8'h00;

    // Status / mask bits
    localparam int st_irq1_bit = 0;
    localparam int st_external_irq_pin_two_bit = 1;
    localparam logic [1:0] stat_reset = 2'h0;
    localparam logic [1:0] mask_reset = 2'h0;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    localparam int presc_width = 10;
    localparam logic [9:0] presc_div64_mask = 10'h03f;
    localparam logic [9:0] presc_div1024_mask = 10'h3ff;
    localparam int sync_stages = 3;

    typedef enum logic [2:0] {
        rtc_src_none,
        rtc_src_div64,
        rtc_src_div1024,
        rtc_src_underflow,
        rtc_src_ext_edge
    } rtc_src_type;

    typedef enum logic [1:0] {
        rtc_mode_plain_8,
        rtc_mode_plain_16,
        rtc_mode_exp_8,
        rtc_mode_exp_16
    } rtc_mode_type;

    typedef struct packed {
        logic exp_n;
        logic clk_ext_sel;
        logic clk_sel_hi;
        logic clk_sel_lo;
        logic wide;
        logic reload;
    } rtc_cfg_type;

    typedef struct packed {
        logic first_underflow;
        logic second_underflow;
    } rtc_evt_type;

endpackage

// ==== design/rtc_edge_sync.sv ====
// Three-stage synchroniser with an edge pulse for a pin input.
// Assumes the pin is asynchronous to core_clk.
module rtc_edge_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic edge_pulse
);
    import rtc_pkg::*;

    logic [sync_stages-1:0] sync_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[sync_stages-2:0], pin_in};
        end
    end

    // Only the second and third stages decide a change: a pulse while they differ
    assign edge_pulse = sync_q[1] ^ sync_q[2];
endmodule

// ==== design/rtc_ctrl.sv ====
// Control logic of a pair of 8-bit reload timers: expansion enable,
// second-timer clock source, operating mode and interrupt gating.
// Assumes an AHB-Lite master and a timer core that reports underflows.
//
// The register addresses and the AHB-Lite slave port were decided locally.

module rtc_ctrl #(
    parameter bit emu_variant = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic external_irq_pin_two,
    input wire rtc_pkg::rtc_evt_type timer_evt,
    output logic second_timer_count_q,
    output rtc_pkg::rtc_mode_type mode_q,
    output logic irq_q
);
    import rtc_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] reload_timer_control_q;
    logic [7:0] reload_timer_mode_reg_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic [9:0] presc_q;
    logic ext_edge;
    rtc_cfg_type cfg;
    rtc_src_type src;
    logic tick;
    logic [31:0] rd_data;
    logic stat_rd;

    function automatic logic [7:0] word_off(input logic [31:0] a);
        word_off = {a[7:2], 2'b00};
    endfunction

    rtc_edge_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_in(external_irq_pin_two),
        .edge_pulse(ext_edge)
    );

    // ----------------------------------------------------------------
    // Bus slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    logic take;
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                addr_q <= word_off(haddr);
            end
        end
    end

    // Zero wait states and no error response; kept in flops so the
    // handshake outputs leave a register like the count, mode and interrupt outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data is formed from the latched address phase
    always_comb begin
        rd_data = 32'h0000_0000;
        case (addr_q)
            ctrl_off: rd_data = {24'h000000, reload_timer_control_q};
            mode_off: rd_data = {24'h000000, reload_timer_mode_reg_q};
            stat_off: rd_data = {30'h0000_0000, stat_q};
            mask_off: rd_data = {30'h0000_0000, mask_q};
            src_off: rd_data = {27'h000_0000, 2'b00, src};
            default: rd_data = 32'h0000_0000;
        endcase
    end
    // Read data stays a decode of the latched address rather than a flop:
    // capturing it in the address phase would miss a write landing in the
    // data phase just before, and would clear status a cycle too early
    assign hrdata = rd_data;
    assign stat_rd = rd_pend_q && (addr_q == stat_off);

    // ----------------------------------------------------------------
    // Control and mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reload_timer_control_q <= ctrl_reset;
        end else if (wr_pend_q && addr_q == ctrl_off) begin
            reload_timer_control_q <= hwdata[7:0];
            // Emulation part keeps expansion disabled for good
            if (emu_variant) begin
                reload_timer_control_q[ctl_exp_n_bit] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reload_timer_mode_reg_q <= mode_reset;
        end else if (wr_pend_q && addr_q == mode_off) begin
            reload_timer_mode_reg_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mask_q <= mask_reset;
        end else if (wr_pend_q && addr_q == mask_off) begin
            mask_q <= hwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Clock source selection
    // ----------------------------------------------------------------
    always_comb begin
        cfg.exp_n = reload_timer_control_q[ctl_exp_n_bit];
        cfg.clk_ext_sel = reload_timer_control_q[ctl_clk_ext_bit];
        cfg.clk_sel_hi = reload_timer_mode_reg_q[mode_sel_hi_bit];
        cfg.clk_sel_lo = reload_timer_mode_reg_q[mode_sel_lo_bit];
        cfg.wide = reload_timer_mode_reg_q[mode_wide_bit];
        cfg.reload = reload_timer_mode_reg_q[mode_reload_bit];
    end

    // Blank and reserved table entries give no count rather than a guess;
    // software must not rely on them
    always_comb begin
        src = rtc_src_none;
        if (!cfg.exp_n && !cfg.clk_ext_sel) begin
            src = rtc_src_none;
        end else begin
            case ({cfg.clk_sel_hi, cfg.clk_sel_lo})
                2'b10: src = rtc_src_underflow;
                2'b11: src = rtc_src_ext_edge;
                2'b01: src = (!cfg.exp_n) ? rtc_src_div64 : rtc_src_none;
                2'b00: src = (cfg.exp_n && !cfg.clk_ext_sel) ?
                    rtc_src_div1024 : rtc_src_none;
                default: src = rtc_src_none;
            endcase
        end
    end

    // Free-running prescaler; its wrap points are the divided ticks
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            presc_q <= 10'h000;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    // The prescaler is never restarted, so the first count after a source
    // change may come early by up to one divided period
    always_comb begin
        case (src)
            rtc_src_div64: tick = (presc_q[5:0] == presc_div64_mask[5:0]);
            rtc_src_div1024: tick = (presc_q == presc_div1024_mask);
            rtc_src_underflow: tick = timer_evt.first_underflow;
            rtc_src_ext_edge: tick = ext_edge;
            default: tick = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            second_timer_count_q <= 1'b0;
        end else begin
            second_timer_count_q <= tick;
        end
    end

    // ----------------------------------------------------------------
    // Operating mode
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_q <= rtc_mode_plain_8;
        end else begin
            case ({cfg.exp_n, cfg.wide})
                2'b00: mode_q <= rtc_mode_exp_8;
                2'b01: mode_q <= rtc_mode_exp_16;
                2'b10: mode_q <= rtc_mode_plain_8;
                default: mode_q <= rtc_mode_plain_16;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: sticky status, read clears, set wins
    // ----------------------------------------------------------------
    logic [1:0] st_set;
    assign st_set[st_irq1_bit] = timer_evt.first_underflow &&
        reload_timer_control_q[ctl_irq1_en_bit];
    assign st_set[st_external_irq_pin_two_bit] = timer_evt.second_underflow &&
        reload_timer_control_q[ctl_external_irq_pin_two_en_bit];

    // A read that meets a new event keeps the event: set wins over clear
    logic [1:0] stat_d;
    assign stat_d = (stat_rd ? 2'b00 : stat_q) | st_set;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stat_q <= stat_reset;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_d & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    exp_reset_one_a: assert property (
        $fell(reset) |-> reload_timer_control_q[ctl_exp_n_bit])
        else $error("expansion bit not 1 after reset");
    emu_fixed_a: assert property (
        emu_variant |-> reload_timer_control_q[ctl_exp_n_bit])
        else $error("emulation expansion bit cleared");
    ctrl_write_a: assert property (
        (wr_pend_q && addr_q == ctrl_off && !emu_variant) |=>
        reload_timer_control_q == $past(hwdata[7:0]))
        else $error("control write lost");
    underflow_a: assert property (
        (src == rtc_src_underflow && timer_evt.first_underflow) |=>
        second_timer_count_q)
        else $error("underflow not counted");
    ext_edge_a: assert property (
        (src == rtc_src_ext_edge && ext_edge) |=> second_timer_count_q)
        else $error("external edge not counted");
    div64_a: assert property (
        (src == rtc_src_div64 && presc_q[5:0] == 6'h3f) |=>
        second_timer_count_q)
        else $error("div64 tick missed");
    div1024_a: assert property (
        (src == rtc_src_div1024 && presc_q != 10'h3ff) |=>
        !second_timer_count_q)
        else $error("div1024 tick early");
    reserved_none_a: assert property (
        (!cfg.exp_n && !cfg.clk_ext_sel) |=> !second_timer_count_q)
        else $error("reserved source counted");
    mode_map_a: assert property (
        (cfg.exp_n && !cfg.wide) ##1 (cfg.exp_n && !cfg.wide) |->
        mode_q == rtc_mode_plain_8)
        else $error("mode mismatch");

    // Mode decode needs the select bits to sit still for one edge
    sequence mode_held_s(logic e, logic w);
        (cfg.exp_n == e && cfg.wide == w) ##1
        (cfg.exp_n == e && cfg.wide == w);
    endsequence

    mode_exp8_a: assert property (
        mode_held_s(1'b0, 1'b0) |-> mode_q == rtc_mode_exp_8)
        else $error("expanded 8-bit mode not selected");
    mode_exp16_a: assert property (
        mode_held_s(1'b0, 1'b1) |-> mode_q == rtc_mode_exp_16)
        else $error("expanded 16-bit mode not selected");
    mode_plain16_a: assert property (
        mode_held_s(1'b1, 1'b1) |-> mode_q == rtc_mode_plain_16)
        else $error("plain 16-bit mode not selected");

    // A pin change needs two quiet edges to pass the synchroniser
    sequence pin_settle_s;
        $changed(external_irq_pin_two) ##1
        $stable(external_irq_pin_two) ##1
        $stable(external_irq_pin_two);
    endsequence

    pin_count_a: assert property (
        (pin_settle_s ##0 src == rtc_src_ext_edge) |=>
        second_timer_count_q)
        else $error("pin edge not counted");
    div64_quiet_a: assert property (
        (src == rtc_src_div64 && presc_q[5:0] != 6'h3f) |=>
        !second_timer_count_q)
        else $error("div64 tick early");

    stat_set_a: assert property (
        (|st_set) |=> ((stat_q & $past(st_set)) == $past(st_set)))
        else $error("event lost against a status read");
    stat_clear_a: assert property (
        (stat_rd && st_set == 2'b00) |=> stat_q == 2'b00)
        else $error("status read did not clear");
    irq1_gate_a: assert property (
        (!reload_timer_control_q[ctl_irq1_en_bit] &&
        !stat_q[st_irq1_bit]) |=> !stat_q[st_irq1_bit])
        else $error("disabled first interrupt set status");
    external_irq_pin_two_gate_a: assert property (
        (!reload_timer_control_q[ctl_external_irq_pin_two_en_bit] &&
        !stat_q[st_external_irq_pin_two_bit]) |=> !stat_q[st_external_irq_pin_two_bit])
        else $error("disabled second interrupt set status");
    irq_level_a: assert property (
        1'b1 |=> irq_q == |(stat_q & $past(mask_q)))
        else $error("interrupt level out of step");
    emu_read_a: assert property (
        (emu_variant && rd_pend_q && addr_q == ctrl_off) |->
        hrdata[ctl_exp_n_bit])
        else $error("emulation expansion bit read as 0");
    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the reload timer pair control block.
// Assumes rtc_pkg and rtc_ctrl are compiled first; the bench is the
// AHB-Lite master and also drives the pin and the underflow pulses.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // Stimulus signals and the two instances
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic pin = 1'b0;
    rtc_evt_type evt = 2'b00;
    logic use_emu = 1'b0;
    logic [31:0] rd_m;
    logic [31:0] rd_e;
    logic rdy;
    logic resp;
    logic cnt;
    logic irq;
    rtc_mode_type mode;
    rtc_mode_type mode_e;
    int err_count = 0;
    int checks = 0;
    // Table of control, mode and expected mode output
    logic [7:0] mc[4] = '{8'h00, 8'h00, 8'h08, 8'h08};
    logic [7:0] mm[4] = '{8'h00, 8'h10, 8'h10, 8'h01};
    rtc_mode_type me[4] = '{rtc_mode_exp_8, rtc_mode_exp_16,
                            rtc_mode_plain_16, rtc_mode_plain_8};
    // Table of control, mode and expected count source
    logic [7:0] sc[8] = '{8'h01, 8'h01, 8'h01, 8'h00,
                          8'h08, 8'h08, 8'h08, 8'h09};
    logic [7:0] sm[8] = '{8'h04, 8'h08, 8'h0c, 8'h04,
                          8'h00, 8'h08, 8'h0c, 8'h00};
    rtc_src_type se[8] = '{rtc_src_div64, rtc_src_underflow,
                           rtc_src_ext_edge, rtc_src_none,
                           rtc_src_div1024, rtc_src_underflow,
                           rtc_src_ext_edge, rtc_src_none};

    rtc_ctrl #(.emu_variant(1'b0)) rtc_ctrl_inst (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(rdy), .hrdata(rd_m), .hreadyout(rdy), .hresp(resp),
        .external_irq_pin_two(pin), .timer_evt(evt),
        .second_timer_count_q(cnt), .mode_q(mode), .irq_q(irq));

    // Emulation variant shares the bus; only its read data and mode output are used
    rtc_ctrl #(.emu_variant(1'b1)) rtc_ctrl_emu_inst (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(rdy), .hrdata(rd_e), .hreadyout(), .hresp(),
        .external_irq_pin_two(pin), .timer_evt(evt),
        .second_timer_count_q(), .mode_q(mode_e), .irq_q());

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Bus, compare and pulse tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        r = use_emu ? rd_e : rd_m;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    // Leaves two edges so the registered outputs have settled
    task automatic cfg(input logic [7:0] c, input logic [7:0] m);
        wr(ctrl_off, {24'h0, c});
        wr(mode_off, {24'h0, m});
        repeat (2) @(posedge core_clk);
    endtask

    task automatic pulse(input logic [1:0] v);
        evt <= v;
        @(posedge core_clk);
        evt <= 2'b00;
        @(posedge core_clk);
    endtask

    // Edges until the next count pulse, capped so a silent source ends
    task automatic wait_cnt(input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (cnt !== 1'b1 && n < lim);
    endtask

    task automatic wrap_up();
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 40);
        err_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic i0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rc(ctrl_off, 32'h09);
        chk({30'h0, mode}, {30'h0, rtc_mode_plain_8});
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, resp}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            cfg(mc[i], mm[i]);
            chk({30'h0, mode}, {30'h0, me[i]});
        end
        rc(mode_off, 32'h01);
        for (int i = 0; i < 8; i++) begin
            cfg(sc[i], sm[i]);
            rc(src_off, {29'h0, se[i]});
        end
        cfg(8'h01, 8'h04);
        wait_cnt(1100, n);
        wait_cnt(1100, n);
        chk(n, 64);
        cfg(8'h08, 8'h00);
        wait_cnt(1100, n);
        wait_cnt(1100, n);
        chk(n, 1024);
        cfg(8'h08, 8'h08);
        pulse(2'b10);
        chk({31'h0, cnt}, 32'h1);
        @(posedge core_clk);
        chk({31'h0, cnt}, 32'h0);
        rc(stat_off, 32'h0);
        cfg(8'h01, 8'h0c);
        wait_cnt(40, n);
        chk(n, 40);
        for (int i = 0; i < 2; i++) begin
            pin <= ~pin;
            wait_cnt(8, n);
            chk({31'h0, cnt}, 32'h1);
        end
        cfg(8'h00, 8'h04);
        wait_cnt(200, n);
        chk(n, 200);
        // Mask polarity is left open, so only a change of output is asked
        cfg(8'h0e, 8'h00);
        wr(mask_off, 32'h0);
        pulse(2'b11);
        @(posedge core_clk);
        i0 = irq;
        wr(mask_off, 32'h3);
        repeat (2) @(posedge core_clk);
        chk({31'h0, i0 ^ irq}, 32'h1);
        rc(stat_off, 32'h3);
        rc(stat_off, 32'h0);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h14, 32'hff);
        rc(8'h14, 32'h0);
        rc(ctrl_off, 32'h0e);
        use_emu = 1'b1;
        cfg(8'h00, 8'h10);
        rc(ctrl_off, 32'h08);
        chk({30'h0, mode_e}, {30'h0, rtc_mode_plain_16});
        wrap_up();
    end
endmodule
